// File: rtl/eng_cmd_inputs.sv
/*
 * Remote binary command inputs of a marine engine controller: harbour
 * override, remote load switch, link fail blocking, emergency halt, remote
 * crank and halt requests and filter burn inhibit, with an APB slave.
 * Assumes pins come from switches in no clock domain and a 10 MHz clock.
 */
// Local design decisions: the register addresses and the APB interface to the registers.
//
// Contract
// - harbour request enters, release restores prior mode.
// - harbour request ignored in local mode.
// - above min load speed, load follows switch.
// - load switch ignored in local mode.
// - link fail block suppresses fail indication.
// - either emergency halt shuts engine down immediately.
// - emergency halt also drops coolant and prelube.
// - shutdown override never masks emergency halt.
// - crank edge acts except in local mode.
// - one start attempt per crank request.
// - failed start logged in alarm and history.
// - second crank edge in idle ends idle.
// - crank request equals panel start key.
// - halt edge cools, second edge stops.
// - halt request ignored in local mode.
// - halt request equals panel stop key.
// - inputs sampled every 100 ms; pulses 120 ms.
// - burn inhibit blocks automatic filter regeneration.
`timescale 1ns/1ps

module eng_cmd_inputs #(
  parameter int unsigned SAMPLE_CYCLES = eng_cmd_pkg::SAMPLE_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic REM_HARBOUR_I,
  input wire logic REM_LOAD_I,
  input wire logic LINK_BLOCK_I,
  input wire logic LINK_FAIL_I,
  input wire logic EMERG_HALT_A_I,
  input wire logic EMERG_HALT_B_I,
  input wire logic SHUTDOWN_OVERRIDE_I,
  input wire logic OTHER_SHUTDOWN_I,
  input wire logic CRANK_REQ_I,
  input wire logic HALT_REQ_I,
  input wire logic REGEN_NEED_I,
  input wire logic BURN_INHIBIT_I,
  output logic LOAD_CONNECT_O,
  output logic COOLANT_PUMP_O,
  output logic PRELUBE_O,
  output logic STARTER_O,
  output logic FUEL_O,
  output logic LINK_FAIL_IND_O,
  output logic REGEN_START_O
);

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  // ********************************************************************
  // Input synchronisers and 100 ms sampling
  // ********************************************************************
  eng_cmd_pkg::bin_t pins;
  eng_cmd_pkg::bin_t sync1;
  eng_cmd_pkg::bin_t sync2;
  eng_cmd_pkg::bin_t samp;
  eng_cmd_pkg::bin_t prev;
  logic [19:0] tick_cnt;
  logic tick;
  logic fresh;

  assign pins = '{REM_HARBOUR_I, REM_LOAD_I, LINK_BLOCK_I, LINK_FAIL_I,
                  EMERG_HALT_A_I, EMERG_HALT_B_I, SHUTDOWN_OVERRIDE_I,
                  OTHER_SHUTDOWN_I, CRANK_REQ_I, HALT_REQ_I, REGEN_NEED_I,
                  BURN_INHIBIT_I};

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 20'(SAMPLE_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 20'h0_0001;
      tick <= 1'b0;
    end
  end

  // A switch that bounces between samples is seen only at sample instants.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      samp <= '0;
      prev <= '0;
      fresh <= 1'b0;
    end else begin
      fresh <= tick;
      if (tick) begin
        samp <= sync2;
        prev <= samp;
      end
    end
  end

  // ********************************************************************
  // Registers written by software
  // ********************************************************************
  logic [2:0] mode_code;
  logic nc_a;
  logic nc_b;
  logic [15:0] speed;
  logic [15:0] min_load;
  logic [15:0] fire_speed;
  logic key_start;
  logic key_stop;
  logic fault_reset;
  logic wr_acc;
  logic rd_setup;

  assign wr_acc = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  function automatic eng_cmd_pkg::mode_t decode_mode(input logic [2:0] code);
    case (code)
      3'h0: decode_mode = eng_cmd_pkg::MODE_AUX;
      3'h1: decode_mode = eng_cmd_pkg::MODE_EME;
      3'h2: decode_mode = eng_cmd_pkg::MODE_HRB;
      3'h3: decode_mode = eng_cmd_pkg::MODE_PRP;
      default: decode_mode = eng_cmd_pkg::MODE_LOC;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == eng_cmd_pkg::CTRL_OFS) || (a == eng_cmd_pkg::KEYS_OFS) ||
             (a == eng_cmd_pkg::SPEED_OFS) || (a == eng_cmd_pkg::MIN_LOAD_OFS) ||
             (a == eng_cmd_pkg::FIRE_SPEED_OFS) || (a == eng_cmd_pkg::STATUS_OFS) ||
             (a == eng_cmd_pkg::HISTORY_OFS);
  endfunction

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      mode_code <= eng_cmd_pkg::MODE_RST;
      nc_a <= 1'b0;
      nc_b <= 1'b0;
      speed <= eng_cmd_pkg::SPEED_RST;
      min_load <= eng_cmd_pkg::MIN_LOAD_RST;
      fire_speed <= eng_cmd_pkg::FIRE_SPEED_RST;
    end else if (wr_acc) begin
      case (PADDR_I)
        eng_cmd_pkg::CTRL_OFS: begin
          mode_code <= PWDATA_I[eng_cmd_pkg::CTRL_MODE_LSB +: 3];
          nc_a <= PWDATA_I[eng_cmd_pkg::CTRL_NC_A_BIT];
          nc_b <= PWDATA_I[eng_cmd_pkg::CTRL_NC_B_BIT];
        end
        eng_cmd_pkg::SPEED_OFS: speed <= PWDATA_I[15:0];
        eng_cmd_pkg::MIN_LOAD_OFS: min_load <= PWDATA_I[15:0];
        eng_cmd_pkg::FIRE_SPEED_OFS: fire_speed <= PWDATA_I[15:0];
        default: ;
      endcase
    end
  end

  // Panel keys are one-cycle pulses from a write to the key register.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      key_start <= 1'b0;
      key_stop <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      key_start <= wr_acc && PADDR_I == eng_cmd_pkg::KEYS_OFS &&
                   PWDATA_I[eng_cmd_pkg::KEY_START_BIT];
      key_stop <= wr_acc && PADDR_I == eng_cmd_pkg::KEYS_OFS &&
                  PWDATA_I[eng_cmd_pkg::KEY_STOP_BIT];
      fault_reset <= wr_acc && PADDR_I == eng_cmd_pkg::KEYS_OFS &&
                     PWDATA_I[eng_cmd_pkg::KEY_RESET_BIT];
    end
  end

  // ********************************************************************
  // Mode selection and requests
  // ********************************************************************
  eng_cmd_pkg::mode_t base_mode;
  eng_cmd_pkg::mode_t mode;
  logic is_loc;
  logic crank_edge;
  logic halt_edge;
  logic start_req;
  logic stop_req;
  logic emerg;
  logic other_sd;

  assign base_mode = decode_mode(mode_code);
  assign is_loc = base_mode == eng_cmd_pkg::MODE_LOC;

  // local wins
  // The base mode is never overwritten, so release falls back to it.
  assign mode = (!is_loc && samp.harbour_req) ? eng_cmd_pkg::MODE_HRB : base_mode;

  assign crank_edge = fresh & samp.crank_req & ~prev.crank_req;
  assign halt_edge = fresh & samp.halt_req & ~prev.halt_req;

  assign start_req = (crank_edge & ~is_loc) | key_start;
  assign stop_req = (halt_edge & ~is_loc) | key_stop;

  assign emerg = (samp.halt_a ^ nc_a) | (samp.halt_b ^ nc_b);
  assign other_sd = samp.other_sd & ~samp.sd_ovr;

  // ********************************************************************
  // Engine sequence
  // ********************************************************************
  eng_cmd_pkg::eng_t state;
  logic [7:0] timer;
  logic emerg_latch;
  logic start_fail;
  logic [15:0] fail_count;
  logic fired;
  logic crank_fail;

  assign fired = speed >= fire_speed;
  assign crank_fail = state == eng_cmd_pkg::ENG_CRANK && !fired && timer == 8'h00;

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      state <= eng_cmd_pkg::ENG_STOP;
      timer <= 8'h00;
    end else if (emerg || other_sd) begin
      state <= eng_cmd_pkg::ENG_STOP;
      timer <= 8'h00;
    end else begin
      if (fresh && timer != 8'h00) begin
        timer <= timer - 8'h01;
      end
      case (state)
        eng_cmd_pkg::ENG_STOP: begin
          if (start_req && !emerg_latch) begin
            state <= eng_cmd_pkg::ENG_CRANK;
            timer <= eng_cmd_pkg::CRANK_TICKS;
          end
        end
        eng_cmd_pkg::ENG_CRANK: begin
          if (fired) begin
            state <= eng_cmd_pkg::ENG_IDLE;
            timer <= eng_cmd_pkg::IDLE_TICKS;
          end else if (stop_req || timer == 8'h00) begin
            state <= eng_cmd_pkg::ENG_STOP;
          end
        end
        eng_cmd_pkg::ENG_IDLE: begin
          if (stop_req) begin
            state <= eng_cmd_pkg::ENG_COOL;
            timer <= eng_cmd_pkg::COOL_TICKS;
          end else if (start_req || timer == 8'h00) begin
            state <= eng_cmd_pkg::ENG_RUN;
          end
        end
        eng_cmd_pkg::ENG_RUN: begin
          if (stop_req) begin
            state <= eng_cmd_pkg::ENG_COOL;
            timer <= eng_cmd_pkg::COOL_TICKS;
          end
        end
        eng_cmd_pkg::ENG_COOL: begin
          if (stop_req || timer == 8'h00) begin
            state <= eng_cmd_pkg::ENG_STOP;
          end
        end
        default: state <= eng_cmd_pkg::ENG_STOP;
      endcase
    end
  end

  // alarm and history
  // A new event in the clearing cycle keeps its flag set.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      start_fail <= 1'b0;
      emerg_latch <= 1'b0;
      fail_count <= 16'h0000;
    end else begin
      start_fail <= crank_fail | (start_fail & ~fault_reset);
      emerg_latch <= emerg | (emerg_latch & ~fault_reset);
      if (crank_fail && fail_count != 16'hFFFF) begin
        fail_count <= fail_count + 16'h0001;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  logic engine_on;

  assign engine_on = state == eng_cmd_pkg::ENG_IDLE || state == eng_cmd_pkg::ENG_RUN ||
                     state == eng_cmd_pkg::ENG_COOL;

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      LOAD_CONNECT_O <= 1'b0;
    end else if (speed <= min_load || emerg) begin
      LOAD_CONNECT_O <= 1'b0;
    end else if (!is_loc) begin
      LOAD_CONNECT_O <= samp.load_sw;
    end
  end

  // pumps drop on emergency
  // Other shutdowns stop the engine, so the pumps drop one cycle after the state reaches stop.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      COOLANT_PUMP_O <= 1'b0;
      PRELUBE_O <= 1'b0;
    end else begin
      COOLANT_PUMP_O <= engine_on & ~emerg & ~emerg_latch;
      PRELUBE_O <= (state == eng_cmd_pkg::ENG_CRANK) & ~emerg & ~emerg_latch;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      STARTER_O <= 1'b0;
      FUEL_O <= 1'b0;
      LINK_FAIL_IND_O <= 1'b0;
      REGEN_START_O <= 1'b0;
    end else begin
      STARTER_O <= state == eng_cmd_pkg::ENG_CRANK && !emerg;
      FUEL_O <= state != eng_cmd_pkg::ENG_STOP && !emerg;
      LINK_FAIL_IND_O <= samp.link_fail & ~samp.link_blk;
      REGEN_START_O <= engine_on & samp.regen_need & ~samp.regen_inh;
    end
  end

  // ********************************************************************
  // APB read side
  // ********************************************************************
  // Read data is captured in the setup cycle; every access has no wait.
  always_ff @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped(PADDR_I);
      if (rd_setup) begin
        case (PADDR_I)
          eng_cmd_pkg::CTRL_OFS: PRDATA_O <= {26'h000_0000, nc_b, nc_a, 1'b0, mode_code};
          eng_cmd_pkg::SPEED_OFS: PRDATA_O <= {16'h0000, speed};
          eng_cmd_pkg::MIN_LOAD_OFS: PRDATA_O <= {16'h0000, min_load};
          eng_cmd_pkg::FIRE_SPEED_OFS: PRDATA_O <= {16'h0000, fire_speed};
          eng_cmd_pkg::STATUS_OFS: PRDATA_O <= {20'h0_0000, start_fail, emerg_latch,
                                                state, mode};
          eng_cmd_pkg::HISTORY_OFS: PRDATA_O <= {16'h0000, fail_count};
          default: PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence run_halt_s;
    state == eng_cmd_pkg::ENG_RUN && stop_req && !emerg && !other_sd;
  endsequence

  sequence cool_halt_s;
    state == eng_cmd_pkg::ENG_COOL && stop_req && !emerg && !other_sd;
  endsequence

  harbour_enter_a: assert property (samp.harbour_req && !is_loc |->
    mode == eng_cmd_pkg::MODE_HRB) else $error("harbour request not honoured");
  local_keep_a: assert property (is_loc |-> mode == eng_cmd_pkg::MODE_LOC)
    else $error("local mode overridden");
  load_follow_a: assert property (speed > min_load && !is_loc && !emerg |=>
    LOAD_CONNECT_O == $past(samp.load_sw)) else $error("load not following switch");
  load_local_a: assert property (is_loc && speed > min_load && !emerg |=>
    $stable(LOAD_CONNECT_O)) else $error("load moved in local mode");
  link_block_a: assert property (samp.link_blk |=> !LINK_FAIL_IND_O)
    else $error("link fail shown while blocked");
  emerg_stop_a: assert property (emerg |=> state == eng_cmd_pkg::ENG_STOP
    && !FUEL_O) else $error("emergency halt did not stop engine");
  emerg_pumps_a: assert property (emerg |=> !COOLANT_PUMP_O && !PRELUBE_O)
    else $error("pumps left on at emergency halt");
  emerg_ovr_a: assert property (emerg && samp.sd_ovr |=>
    state == eng_cmd_pkg::ENG_STOP) else $error("override masked emergency");
  local_crank_a: assert property (state == eng_cmd_pkg::ENG_STOP && is_loc &&
    !key_start |=> state == eng_cmd_pkg::ENG_STOP) else $error("crank in local");
  one_attempt_a: assert property (crank_fail && !emerg && !other_sd |=>
    state == eng_cmd_pkg::ENG_STOP ##1 state == eng_cmd_pkg::ENG_STOP)
    else $error("cranking repeated");
  fail_log_a: assert property (crank_fail |=> start_fail &&
    fail_count != $past(fail_count)) else $error("start failure not logged");
  idle_skip_a: assert property (state == eng_cmd_pkg::ENG_IDLE && start_req &&
    !stop_req && !emerg && !other_sd |=> state == eng_cmd_pkg::ENG_RUN)
    else $error("idle not skipped");
  halt_seq_a: assert property (run_halt_s |=> state == eng_cmd_pkg::ENG_COOL
    ##0 timer == eng_cmd_pkg::COOL_TICKS) else $error("halt did not start cooling");
  cool_skip_a: assert property (cool_halt_s |=> state == eng_cmd_pkg::ENG_STOP)
    else $error("second halt did not stop");
  local_halt_a: assert property (state == eng_cmd_pkg::ENG_RUN && is_loc &&
    !key_stop |=> state != eng_cmd_pkg::ENG_COOL) else $error("halt in local");
  sample_rate_a: assert property (tick |=> !tick)
    else $error("sample tick too frequent");
  regen_block_a: assert property (samp.regen_inh |=> !REGEN_START_O)
    else $error("regeneration started while inhibited");
  edge_once_a: assert property (crank_edge |=> !crank_edge)
    else $error("crank edge counted twice");

endmodule // eng_cmd_inputs

// File: rtl/eng_cmd_pkg.sv
/*
 * Shared constants and types for the remote engine command input logic.
 * Assumes a single 10 MHz clock and APB register access with 32-bit data.
 */
package eng_cmd_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SAMPLE_PERIOD_MS = 100;
  localparam int unsigned MIN_PULSE_MS = 120;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // Sequence times counted in input sample periods.
  localparam logic [7:0] CRANK_TICKS = 8'h32;
  localparam logic [7:0] IDLE_TICKS = 8'h64;
  localparam logic [7:0] COOL_TICKS = 8'hC8;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] KEYS_OFS = 8'h04;
  localparam logic [7:0] SPEED_OFS = 8'h08;
  localparam logic [7:0] MIN_LOAD_OFS = 8'h0C;
  localparam logic [7:0] FIRE_SPEED_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] HISTORY_OFS = 8'h18;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_NC_A_BIT = 4;
  localparam int CTRL_NC_B_BIT = 5;
  localparam int KEY_START_BIT = 0;
  localparam int KEY_STOP_BIT = 1;
  localparam int KEY_RESET_BIT = 2;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_STATE_LSB = 5;
  localparam int ST_EMERG_BIT = 10;
  localparam int ST_FAIL_BIT = 11;

  localparam logic [2:0] MODE_RST = 3'h4;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [15:0] MIN_LOAD_RST = 16'h0258;
  localparam logic [15:0] FIRE_SPEED_RST = 16'h012C;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [4:0] {
    MODE_AUX = 5'b00001,
    MODE_EME = 5'b00010,
    MODE_HRB = 5'b00100,
    MODE_PRP = 5'b01000,
    MODE_LOC = 5'b10000
  } mode_t;

  typedef enum logic [4:0] {
    ENG_STOP = 5'b00001,
    ENG_CRANK = 5'b00010,
    ENG_IDLE = 5'b00100,
    ENG_RUN = 5'b01000,
    ENG_COOL = 5'b10000
  } eng_t;

  typedef struct packed {
    logic harbour_req;
    logic load_sw;
    logic link_blk;
    logic link_fail;
    logic halt_a;
    logic halt_b;
    logic sd_ovr;
    logic other_sd;
    logic crank_req;
    logic halt_req;
    logic regen_need;
    logic regen_inh;
  } bin_t;

endpackage

// File: test/eng_switch_model.sv
/*
 * Model of the external switches and contacts wired to the command pins.
 * Assumes the bench calls its tasks from one process, on a 10 MHz clock.
 */
`timescale 1ns/1ps
// ********************************************************************
// Switch and contact model
// ********************************************************************
module eng_switch_model #(
  parameter int unsigned SAMPLE_CYCLES = 20
) (
  input wire logic clk_i,
  output eng_cmd_pkg::bin_t pins_o
);
  eng_cmd_pkg::bin_t sw;
  initial sw = '0;
  // normally closed halts: a pressed halt opens its contact.
  always_comb begin
    pins_o = sw;
    pins_o.halt_a = ~sw.halt_a;
    pins_o.halt_b = ~sw.halt_b;
  end
  task automatic set(input eng_cmd_pkg::bin_t v);
    @(posedge clk_i);
    sw <= v;
  endtask
  // pulse hold: three sample periods, well above the minimum.
  task automatic pulse(input bit halt);
    @(posedge clk_i);
    if (halt) begin
      sw.halt_req <= 1'b1;
    end else begin
      sw.crank_req <= 1'b1;
    end
    repeat (3 * SAMPLE_CYCLES) @(posedge clk_i);
    sw.halt_req <= 1'b0;
    sw.crank_req <= 1'b0;
    repeat (3 * SAMPLE_CYCLES) @(posedge clk_i);
  endtask
endmodule // eng_switch_model

// File: test/tb_top.sv
/*
 * Self-checking bench for the remote engine command input logic.
 * Assumes the design package is compiled first; the sample period is shortened.
 */
`timescale 1ns/1ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
// ********************************************************************
// Bench top
// ********************************************************************
module tb_top;
  localparam int unsigned S = 20;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, load, pump, prelube, starter, fuel, link_ind, regen;
  eng_cmd_pkg::bin_t pins;
  eng_cmd_pkg::bin_t sw_v = '0;
  int fail_count = 0;
  int tests_run = 0;
  always #50 mclk = ~mclk;
  eng_switch_model #(.SAMPLE_CYCLES(S)) eng_switch_model_inst (.clk_i(mclk), .pins_o(pins));
  eng_cmd_inputs #(.SAMPLE_CYCLES(S)) eng_cmd_inputs_inst (
    .MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .REM_HARBOUR_I(pins.harbour_req),
    .REM_LOAD_I(pins.load_sw), .LINK_BLOCK_I(pins.link_blk), .LINK_FAIL_I(pins.link_fail),
    .EMERG_HALT_A_I(pins.halt_a), .EMERG_HALT_B_I(pins.halt_b),
    .SHUTDOWN_OVERRIDE_I(pins.sd_ovr), .OTHER_SHUTDOWN_I(pins.other_sd),
    .CRANK_REQ_I(pins.crank_req), .HALT_REQ_I(pins.halt_req),
    .REGEN_NEED_I(pins.regen_need), .BURN_INHIBIT_I(pins.regen_inh),
    .LOAD_CONNECT_O(load), .COOLANT_PUMP_O(pump), .PRELUBE_O(prelube),
    .STARTER_O(starter), .FUEL_O(fuel), .LINK_FAIL_IND_O(link_ind), .REGEN_START_O(regen));

  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers is a failure, not a silent read of stale data.
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    `CHECK(rd, x)
  endtask
  task automatic wait_st(input logic [9:0] x);
    logic [31:0] rd;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, eng_cmd_pkg::STATUS_OFS, 32'h0000_0000, rd, e);
      n++;
    end while (rd[9:0] !== x && n < 700);
    `CHECK(rd[9:0], x)
  endtask
  task automatic settle();
    eng_switch_model_inst.set(sw_v);
    repeat (3 * S) @(posedge mclk);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic e;
    rd_chk(eng_cmd_pkg::STATUS_OFS, 32'h0000_0030);
    rd_chk(eng_cmd_pkg::CTRL_OFS, {29'h0, eng_cmd_pkg::MODE_RST});
    rd_chk(eng_cmd_pkg::MIN_LOAD_OFS, {16'h0, eng_cmd_pkg::MIN_LOAD_RST});
    rd_chk(eng_cmd_pkg::FIRE_SPEED_OFS, {16'h0, eng_cmd_pkg::FIRE_SPEED_RST});
    apb(1'b0, 8'h1C, 32'h0000_0000, rd, e);
    `CHECK({e, rd}, {1'b1, 32'h0000_0000})
    wr_reg(eng_cmd_pkg::CTRL_OFS, 32'h0000_0034);
    wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0004);
    $display("test reset done");
  endtask
  task automatic t_local();
    wr_reg(eng_cmd_pkg::SPEED_OFS, 32'h0000_0300);
    sw_v.harbour_req = 1'b1;
    sw_v.load_sw = 1'b1;
    settle();
    eng_switch_model_inst.pulse(1'b0);
    eng_switch_model_inst.pulse(1'b1);
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_LOC});
    `CHECK(load, 1'b0)
    sw_v = '0;
    settle();
    $display("test local done");
  endtask
  task automatic t_harbour();
    wr_reg(eng_cmd_pkg::CTRL_OFS, 32'h0000_0030);
    sw_v.harbour_req = 1'b1;
    settle();
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_HRB});
    sw_v.harbour_req = 1'b0;
    settle();
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_AUX});
    $display("test harbour done");
  endtask
  task automatic t_crank_fail();
    logic [31:0] rd;
    logic e;
    wr_reg(eng_cmd_pkg::SPEED_OFS, 32'h0000_0000);
    eng_switch_model_inst.pulse(1'b0);
    `CHECK({starter, prelube}, 2'b11)
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_AUX});
    repeat (4 * S) @(posedge mclk);
    `CHECK(starter, 1'b0)
    rd_chk(eng_cmd_pkg::HISTORY_OFS, 32'h0000_0001);
    apb(1'b0, eng_cmd_pkg::STATUS_OFS, 32'h0000_0000, rd, e);
    `CHECK(rd[eng_cmd_pkg::ST_FAIL_BIT], 1'b1)
    wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0004);
    $display("test crank failure done");
  endtask
  task automatic t_run();
    wr_reg(eng_cmd_pkg::SPEED_OFS, 32'h0000_0300);
    eng_switch_model_inst.pulse(1'b0);
    wait_st({eng_cmd_pkg::ENG_IDLE, eng_cmd_pkg::MODE_AUX});
    eng_switch_model_inst.pulse(1'b0);
    // Idle has far more time left, so only the second edge can show run here.
    rd_chk(eng_cmd_pkg::STATUS_OFS, {22'h00_0000, eng_cmd_pkg::ENG_RUN, eng_cmd_pkg::MODE_AUX});
    sw_v.load_sw = 1'b1;
    sw_v.link_fail = 1'b1;
    sw_v.link_blk = 1'b1;
    sw_v.regen_need = 1'b1;
    sw_v.regen_inh = 1'b1;
    settle();
    `CHECK({load, link_ind, regen}, 3'b100)
    sw_v.load_sw = 1'b0;
    sw_v.link_blk = 1'b0;
    sw_v.regen_inh = 1'b0;
    settle();
    `CHECK({load, link_ind, regen}, 3'b011)
    sw_v = '0;
    settle();
    eng_switch_model_inst.pulse(1'b1);
    wait_st({eng_cmd_pkg::ENG_COOL, eng_cmd_pkg::MODE_AUX});
    eng_switch_model_inst.pulse(1'b1);
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_AUX});
    $display("test run done");
  endtask
  task automatic t_emerg();
    for (int i = 0; i < 2; i++) begin
      wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0001);
      wait_st({eng_cmd_pkg::ENG_IDLE, eng_cmd_pkg::MODE_AUX});
      `CHECK(pump, 1'b1)
      sw_v.sd_ovr = 1'b1;
      sw_v.halt_a = (i == 0);
      sw_v.halt_b = (i == 1);
      settle();
      `CHECK({fuel, pump, prelube, starter}, 4'b0000)
      wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_AUX});
      sw_v = '0;
      settle();
      wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0004);
    end
    $display("test emergency done");
  endtask

  task automatic t_other();
    wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0001);
    wait_st({eng_cmd_pkg::ENG_IDLE, eng_cmd_pkg::MODE_AUX});
    sw_v.other_sd = 1'b1;
    sw_v.sd_ovr = 1'b1;
    settle();
    rd_chk(eng_cmd_pkg::STATUS_OFS, {22'h00_0000, eng_cmd_pkg::ENG_IDLE, eng_cmd_pkg::MODE_AUX});
    sw_v.sd_ovr = 1'b0;
    settle();
    `CHECK({fuel, starter}, 2'b00)
    wait_st({eng_cmd_pkg::ENG_STOP, eng_cmd_pkg::MODE_AUX});
    sw_v = '0;
    settle();
    wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0001);
    wait_st({eng_cmd_pkg::ENG_IDLE, eng_cmd_pkg::MODE_AUX});
    // A reset while the engine idles must drop every output at once.
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    `CHECK({fuel, pump, starter, prelube, load, link_ind, regen}, 7'h00)
    rd_chk(eng_cmd_pkg::STATUS_OFS, 32'h0000_0030);
    rd_chk(eng_cmd_pkg::HISTORY_OFS, 32'h0000_0000);
    wr_reg(eng_cmd_pkg::CTRL_OFS, 32'h0000_0030);
    settle();
    wr_reg(eng_cmd_pkg::KEYS_OFS, 32'h0000_0004);
    rd_chk(eng_cmd_pkg::STATUS_OFS, 32'h0000_0021);
    $display("test other shutdown and reset done");
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A hang anywhere is cut short well after the tests' own length.
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_local();
    t_harbour();
    t_crank_fail();
    t_run();
    t_emerg();
    t_other();
    stop_test();
  end
endmodule // tb_top
